// ==== logic/ccrs_consts.vh ====
// Constants for the core clock and reset sequencer.
`ifndef CCRS_CONSTS_VH
`define CCRS_CONSTS_VH
`define CCRS_ADDR_PMC 4'h0
`define CCRS_ADDR_STAT 4'h4
`define CCRS_PMC_RESET 16'h0000
`define CCRS_PMC_PAD 16'h0000
`define CCRS_STAT_PAD 27'h0
`define CCRS_DIV_START 2'h0
`define CCRS_LANE_W 8
`define CCRS_PMC_LANES 2
`define CCRS_PMC_MULT_LSB 0
`define CCRS_PMC_MULT_MSB 5
`define CCRS_PMC_DIV_LSB 6
`define CCRS_PMC_DIV_MSB 7
`define CCRS_PMC_PINSEL_BIT 12
`define CCRS_RATIO_3 2'h0
`define CCRS_RATIO_16 2'h1
`define CCRS_RATIO_8 2'h2
`define CCRS_RATIO_RSVD 2'h3
`define CCRS_MULT_3 6'h03
`define CCRS_MULT_16 6'h10
`define CCRS_MULT_8 6'h08
`define CCRS_LOCK_CYCLES 4096
`endif

// ==== logic/ccrs_core_clock_reset_sequencer.v ====
// Core clock selection, PLL lock wait and reset sequencing with a Wishbone register port.
// Operation
// [RQ1] The core clock comes from the PLL or straight from the reference clock as the ratio pins choose.
// [RQ2] The start-up core frequency is taken from the ratio pins sampled when hardware reset is released.
// [RQ3] Ratio code 00 gives 3:1, 01 gives 16:1, 10 gives 8:1 and 11 is reserved.
// [RQ4] Once the core is out of reset software may rewrite the PLL multiplier and divider at any time.
// [RQ5] Bit 12 of the power control register puts the PLL clock on the shared pin, else reset-out, the default.
// [RQ6] In reset-out function the shared pin shows the internal core reset state.
// [RQ7] After hardware reset is released the block waits 4096 reference cycles then starts the core at its vector.
// [RQ8] The system holds the hardware reset input low during power-up.
// [RQ9] The reference clock runs continuously at a fixed frequency.
// [RQ10] During hardware reset and the lock wait the core stays in reset and reset-out stays asserted.
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "ccrs_consts.vh"
module ccrs_core_clock_reset_sequencer #(
	parameter LOCK_CYCLES = `CCRS_LOCK_CYCLES
) (
	input wire clk_sys,
	input wire reset_n,
	input wire ref_clock_tick,
	input wire [1:0] ratio_select_pins,
	input wire pll_clock_in,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg core_reset_n,
	output reg core_clk_from_pll,
	output reg [5:0] pll_mult,
	output reg [1:0] pll_div,
	output reg reset_to_external_n,
	output reg pll_clock_out
);
	localparam ST_RESET = 2'h0;
	localparam ST_LOCK = 2'h1;
	localparam ST_RUN = 2'h2;
	localparam [31:0] LOCK_LAST_FULL = LOCK_CYCLES - 1;

	// Start-up multiplier for each ratio code; the reserved code falls back to the 3:1 setting.
	function [5:0] ratio_mult;
		input [1:0] code;
		begin
			case (code)
				`CCRS_RATIO_3: ratio_mult = `CCRS_MULT_3;
				`CCRS_RATIO_16: ratio_mult = `CCRS_MULT_16;
				`CCRS_RATIO_8: ratio_mult = `CCRS_MULT_8;
				default: ratio_mult = `CCRS_MULT_3;
			endcase
		end
	endfunction

	// The reserved code bypasses the PLL and runs the core straight from the reference clock.
	function ratio_uses_pll;
		input [1:0] code;
		begin
			ratio_uses_pll = (code != `CCRS_RATIO_RSVD);
		end
	endfunction

	// Address decode, shared by the write and read paths.
	function addr_is_pmc;
		input [3:0] adr;
		begin
			addr_is_pmc = (adr == `CCRS_ADDR_PMC);
		end
	endfunction

	function addr_is_stat;
		input [3:0] adr;
		begin
			addr_is_stat = (adr == `CCRS_ADDR_STAT);
		end
	endfunction

	// Status word: strap code, sequencer state and the core reset level.
	function [31:0] status_word;
		input [1:0] code;
		input [1:0] st;
		input core_run;
		begin
			status_word = {`CCRS_STAT_PAD, code, st, core_run};
		end
	endfunction

	function [31:0] pmc_read_word;
		input [15:0] word;
		begin
			pmc_read_word = {`CCRS_PMC_PAD, word};
		end
	endfunction

	function [5:0] pmc_mult_field;
		input [15:0] word;
		begin
			pmc_mult_field = word[`CCRS_PMC_MULT_MSB:`CCRS_PMC_MULT_LSB];
		end
	endfunction

	function [1:0] pmc_div_field;
		input [15:0] word;
		begin
			pmc_div_field = word[`CCRS_PMC_DIV_MSB:`CCRS_PMC_DIV_LSB];
		end
	endfunction

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [12:0] lock_cnt_r;
	reg [12:0] lock_cnt_nxt;
	reg [1:0] ratio_r;
	reg [15:0] pmc_r;
	reg [15:0] pmc_nxt;
	reg [31:0] rd_word;
	reg ext_reset_nxt;
	reg clock_out_nxt;
	wire [12:0] lock_last;
	wire lock_done;
	wire wb_req;
	wire wb_rd;
	wire wr_pmc;
	wire load_straps;
	wire pin_sel_clk;
	wire [15:0] pmc_wr_merge;
	genvar lane;

	assign lock_last = LOCK_LAST_FULL[12:0];
	assign lock_done = (lock_cnt_r == lock_last);
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_rd = wb_req & ~wb_we_i;
	assign wr_pmc = wb_req & wb_we_i & addr_is_pmc(wb_adr_i) & (state_r == ST_RUN); // see [RQ4]
	assign load_straps = (state_r == ST_LOCK) & (lock_cnt_r == 13'h0000);
	assign pin_sel_clk = pmc_r[`CCRS_PMC_PINSEL_BIT];

	// Next state of the sequencer; the lock counter only moves on reference clock ticks.
	always @* begin
		state_nxt = state_r;
		lock_cnt_nxt = lock_cnt_r;
		case (state_r)
			ST_RESET: begin
				state_nxt = ST_LOCK;
				lock_cnt_nxt = 13'h0000;
			end
			ST_LOCK: begin
				if (ref_clock_tick) begin
					if (lock_done) begin
						state_nxt = ST_RUN; // see [RQ7]
					end else begin
						lock_cnt_nxt = lock_cnt_r + 13'h0001;
					end
				end
			end
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_RESET;
			end
		endcase
	end

	// Only a hardware reset sends the sequencer back to its start.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			state_r <= ST_RESET;
			lock_cnt_r <= 13'h0000;
		end else begin
			state_r <= state_nxt;
			lock_cnt_r <= lock_cnt_nxt;
		end
	end

	// The straps are caught once, on the first clock after release; later changes are ignored.
	always @(posedge clk_sys) begin
		if (state_r == ST_RESET && reset_n) begin
			ratio_r <= ratio_select_pins; // see [RQ2]
		end
	end

	// Core reset stays asserted through hardware reset and the whole lock wait.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			core_reset_n <= 1'b0; // see [RQ10]
		end else begin
			core_reset_n <= (state_nxt == ST_RUN); // see [RQ7]
		end
	end

	// Byte lanes of a control write; only the two low lanes hold bits.
	generate
		for (lane = 0; lane < `CCRS_PMC_LANES; lane = lane + 1) begin : g_pmc_lane
			wire lane_we;
			assign lane_we = wr_pmc & wb_sel_i[lane];
			assign pmc_wr_merge[lane * `CCRS_LANE_W +: `CCRS_LANE_W] = lane_we ?
				wb_dat_i[lane * `CCRS_LANE_W +: `CCRS_LANE_W] : pmc_r[lane * `CCRS_LANE_W +: `CCRS_LANE_W];
		end
	endgenerate

	// Strap load and software writes never meet: writes are only taken in the run state.
	always @* begin
		pmc_nxt = pmc_r;
		if (load_straps) begin
			pmc_nxt[`CCRS_PMC_MULT_MSB:`CCRS_PMC_MULT_LSB] = ratio_mult(ratio_r); // see [RQ3]
			pmc_nxt[`CCRS_PMC_DIV_MSB:`CCRS_PMC_DIV_LSB] = `CCRS_DIV_START;
		end else if (wr_pmc) begin
			pmc_nxt = pmc_wr_merge; // see [RQ4]
		end
	end

	// A hardware reset puts the shared pin back to its reset-out function.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pmc_r <= `CCRS_PMC_RESET; // see [RQ5]
		end else begin
			pmc_r <= pmc_nxt;
		end
	end

	// Ack comes one cycle after a request and stands for one cycle.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// Unmapped addresses read as zero.
	always @* begin
		rd_word = 32'h0000_0000;
		if (addr_is_pmc(wb_adr_i)) begin
			rd_word = pmc_read_word(pmc_r);
		end else if (addr_is_stat(wb_adr_i)) begin
			rd_word = status_word(ratio_r, state_r, core_reset_n);
		end
	end

	// Read data stands until the next read.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_rd) begin
			wb_dat_o <= rd_word;
		end
	end

	// The source choice follows the strap code caught at release.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			core_clk_from_pll <= 1'b0;
		end else begin
			core_clk_from_pll <= ratio_uses_pll(ratio_r); // see [RQ1]
		end
	end

	// PLL settings follow the control word one cycle later.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pll_mult <= `CCRS_MULT_3;
		end else begin
			pll_mult <= pmc_mult_field(pmc_r);
		end
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pll_div <= `CCRS_DIV_START;
		end else begin
			pll_div <= pmc_div_field(pmc_r);
		end
	end

	// The shared pin is split in two: reset-out is held inactive while the pin carries the clock.
	always @* begin
		ext_reset_nxt = core_reset_n;
		clock_out_nxt = 1'b0;
		if (pin_sel_clk) begin
			ext_reset_nxt = 1'b1; // see [RQ5]
			clock_out_nxt = pll_clock_in;
		end
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			reset_to_external_n <= 1'b0; // see [RQ10]
		end else begin
			reset_to_external_n <= ext_reset_nxt; // see [RQ6]
		end
	end

	// The clock half is a sampled copy of the PLL clock.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pll_clock_out <= 1'b0;
		end else begin
			pll_clock_out <= clock_out_nxt;
		end
	end
endmodule // ccrs_core_clock_reset_sequencer

// ==== verif/ccrs_src.sv ====
// Free-running reference and PLL clock model for the sequencer.
`timescale 1ns/1ps
module ccrs_src (input wire clk_sys, output logic ref_clock_tick = 0, output logic pll_clock_in = 0);
	always @(posedge clk_sys) {ref_clock_tick, pll_clock_in} <= {!ref_clock_tick, !pll_clock_in};
endmodule // ccrs_src

// ==== verif/ccrs_chk.sv ====
// Assertions for the clock and reset sequencer.
`timescale 1ns/1ps
module ccrs_chk (input wire clk_sys, reset_n, wb_ack_o, core_reset_n, core_clk_from_pll, reset_to_external_n,
	input wire pll_clock_out, input wire [1:0] ratio_select_pins, input wire [5:0] pll_mult);
	logic [1:0] s_r;
	always @(posedge clk_sys) if ($rose(reset_n)) s_r <= ratio_select_pins;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_rel_low: assert property ($rose(reset_n) |-> !core_reset_n && !reset_to_external_n) else $error("run");
	a_lock_wait: assert property ($rose(reset_n) |=> !core_reset_n) else $error("lock");
	a_run_keep: assert property (core_reset_n |=> core_reset_n) else $error("drop");
	a_out_follow: assert property (!core_reset_n |-> !reset_to_external_n) else $error("out");
	a_pin_mux: assert property (pll_clock_out |-> reset_to_external_n) else $error("mux");
	a_clk_src: assert property (core_reset_n |-> core_clk_from_pll == (s_r != 2'h3)) else $error("src");
	a_start_mult: assert property ($rose(core_reset_n) |->
		pll_mult == (s_r == 2'h1 ? 6'h10 : s_r == 2'h2 ? 6'h08 : 6'h03)) else $error("mult");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
	c_run: cover property ($rose(core_reset_n));
	c_pin: cover property (pll_clock_out);
	c_src: cover property (!core_clk_from_pll);
endmodule // ccrs_chk
bind ccrs_core_clock_reset_sequencer ccrs_chk chk (.*);

// ==== verif/test_core_clock_reset_sequencer.sv ====
// Bench for the clock and reset sequencer.
`timescale 1ns/1ps
module test_core_clock_reset_sequencer;
	logic clk_sys = 0, reset_n = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, ref_clock_tick, pll_clock_in;
	logic wb_ack_o, core_reset_n, core_clk_from_pll, reset_to_external_n, pll_clock_out;
	logic [1:0] ratio_select_pins = 0, pll_div;
	logic [3:0] wb_adr_i = 0, wb_sel_i = 4'hf;
	logic [5:0] pll_mult;
	logic [31:0] wb_dat_i = 0, wb_dat_o, d, q[$];
	int n_mismatch = 0, compares = 0;
	always #20 clk_sys = !clk_sys;
	ccrs_src src (.*);
	ccrs_core_clock_reset_sequencer #(.LOCK_CYCLES(8)) uut (.*);
	task ck(input [31:0] s, e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h", $time, s);
		end
	endtask
	task wb(input [3:0] a, input [31:0] v);
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_adr_i, wb_we_i, wb_dat_i} <= {2'h3, a, !a[2], v};
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task results;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_sys) if (wb_ack_o === 1'b1 && !wb_we_i) ck(wb_dat_o, q.pop_front());
	initial #100000 begin
		n_mismatch++;
		results;
	end
	initial begin
		void'($urandom(32'h1de6));
		for (int k = 0; k < 4; k++) begin
			reset_n <= 0;
			ratio_select_pins <= k[1:0];
			repeat (12) @(posedge clk_sys);
			reset_n <= 1;
			@(posedge clk_sys);
			ratio_select_pins <= ~k[1:0];
			do @(posedge clk_sys); while (core_reset_n !== 1'b1);
			@(posedge clk_sys);
			ck({core_clk_from_pll, reset_to_external_n, pll_clock_out}, {k != 3, 2'h2});
			q.push_back(32'({k[1:0], 3'h5}));
			wb(4'h4, 0);
			d = $urandom;
			wb(4'h0, d | 32'h1000);
			repeat (2) @(posedge clk_sys);
			ck({pll_div, pll_mult, reset_to_external_n}, {d[7:0], 1'b1});
		end
		results;
	end
endmodule // test_core_clock_reset_sequencer
